// [fmi_pkg.sv]
// Purpose: Shared constants and types of the flow meter serial command target.
// Assumes: 50 MHz system clock, AHB-Lite register access, 7-bit serial addressing.
// Notes: Word checksums are CRC-8 over the two bytes of each word.
package fmi_pkg;

  // ==========================================================
  // Serial link
  localparam logic [6:0] DEV_ADDR = 7'h2E;
  localparam logic [15:0] CMD_START = 16'h3603;
  localparam logic [15:0] CMD_AVERAGE = 16'h366A;
  localparam logic [15:0] CMD_STOP = 16'h3FF0;
  localparam logic [15:0] CMD_SOFT_RESET = 16'h0006;
  localparam logic [2:0] RX_CMD_ONLY = 3'h2;
  localparam logic [2:0] RX_WITH_ARG = 3'h5;
  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [7:0] CRC_INIT = 8'hFF;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;

  // ==========================================================
  // Filter and averaging
  localparam logic [15:0] FILT_1MS = 16'h8341;
  localparam logic [15:0] FILT_3MS = 16'hC711;
  localparam logic [15:0] FILT_5MS = 16'hDB29;
  localparam logic [15:0] FILT_10MS = 16'hEC6F;
  localparam logic [2:0] RESP_1MS = 3'h0;
  localparam logic [2:0] RESP_3MS = 3'h1;
  localparam logic [2:0] RESP_5MS = 3'h2;
  localparam logic [2:0] RESP_10MS = 3'h3;
  localparam logic [2:0] RESP_OTHER = 3'h7;
  localparam logic [8:0] AVG_MAX = 9'h080;
  localparam logic [8:0] AVG_DEFAULT = 9'h002;
  localparam logic [7:0] AUR_MAX_SAMPLES = 8'h80;
  localparam logic [3:0] MEAS_ID_AIR = 4'h0;

  // ==========================================================
  // Status word field positions
  localparam int ST_ID_LSB = 12;
  localparam int ST_SMOOTH_BIT = 11;
  localparam int ST_FIXED_BIT = 10;
  localparam int ST_ARG_BIT = 9;

  // ==========================================================
  // Register map (byte addresses and status register bit positions)
  localparam logic [7:0] REG_SAMPLE = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CONFIG = 8'h08;
  localparam int RS_MEAS = 0;
  localparam int RS_READY = 1;
  localparam int RS_STOPPING = 2;
  localparam int RS_ARG = 3;
  localparam int RS_SMOOTH = 4;
  localparam int RS_RESP_LSB = 5;
  localparam int RS_FILT_LSB = 16;

  // ==========================================================
  // Timing
  localparam int CLK_HZ = 50_000_000;
  localparam int WARM_TIME_MS = 4;
  localparam real STOP_TIME_MS = 0.5;
  localparam int WARM_CYCLES = (WARM_TIME_MS * CLK_HZ + 999) / 1000;
  localparam int STOP_CYCLES = int'($floor(STOP_TIME_MS * CLK_HZ / 1000.0));

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_RX = 3'b010,
    ST_ACKW = 3'b011,
    ST_ACK = 3'b100,
    ST_TX = 3'b101,
    ST_MACK = 3'b110
  } fmi_st_t;

endpackage : fmi_pkg

// [fmi_crc8.sv]
// Purpose: CRC-8 of one 16-bit word, high byte first.
// Assumes: Purely combinational, used for both receive check and transmit.
// Notes: Polynomial and seed come from the package.
`timescale 1ns/1ps
module fmi_crc8
  import fmi_pkg::*;
(
  input wire logic [15:0] word_in, // Word to protect
  output logic [7:0] crc_out // Checksum of the word
);

  logic [7:0] crc;
  logic fb;

  always_comb
  begin
    crc = CRC_INIT;
    fb = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      fb = crc[7] ^ word_in[i];
      crc = {crc[6:0], 1'b0};
      if (fb)
      begin
        crc = crc ^ CRC_POLY;
      end
    end
    crc_out = crc;
  end

endmodule : fmi_crc8

// [fmi_top.sv]
// Purpose: Serial command target of a gas flow meter with AHB-Lite sample port.
// Assumes: SCL and SDA arrive asynchronously; software feeds samples over AHB.
// Notes: Zero-wait-state slave; commands execute at the closing STOP or a repeated START.
//
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
module fmi_top
  import fmi_pkg::*;
#(
  parameter int WARM_CYC = WARM_CYCLES,
  parameter int STOP_CYC = STOP_CYCLES
)
(
  input wire logic CLK_IN, // 50 MHz clock
  input wire logic SYS_RST_IN, // Sync reset, active high
  input wire logic HSEL_IN, // AHB slave select
  input wire logic [31:0] HADDR_IN, // AHB address
  input wire logic [1:0] HTRANS_IN, // AHB transfer type
  input wire logic HWRITE_IN, // AHB write
  input wire logic [2:0] HSIZE_IN, // AHB size, word only
  input wire logic [31:0] HWDATA_IN, // AHB write data
  input wire logic HREADY_IN, // AHB bus ready
  output logic HREADYOUT_OUT, // AHB slave ready
  output logic HRESP_OUT, // AHB response, always OKAY
  output logic [31:0] HRDATA_OUT, // AHB read data
  input wire logic SCL_IN, // Serial clock pin
  input wire logic SDA_IN, // Serial data pin level
  output logic SDA_OUT, // Serial data drive value
  output logic SDA_OE_OUT, // Serial data drive enable
  output logic HEATER_OUT // Heater on while measuring
);

  localparam int TMR_MAX = (WARM_CYC > STOP_CYC) ? WARM_CYC : STOP_CYC;
  localparam int TMR_W = $clog2(TMR_MAX + 1);

  typedef struct packed {
    logic [2:0] scl_sy;
    logic [2:0] sda_sy;
    fmi_st_t st;
    logic [3:0] bit_cnt;
    logic [7:0] sh;
    logic rw;
    logic sel;
    logic ack;
    logic sda_oe;
    logic [2:0] rx_cnt;
    logic [15:0] cmd;
    logic [15:0] arg;
    logic [7:0] arg_crc;
    logic [1:0] word_idx;
    logic [1:0] byte_pos;
    logic [15:0] flow;
    logic [15:0] temp;
    logic [15:0] tx_flow;
    logic [15:0] tx_temp;
    logic [15:0] tx_stat;
    logic meas;
    logic ready;
    logic stopping;
    logic arg_rcv;
    logic [15:0] filt;
    logic [8:0] avg;
    logic [7:0] smooth_cnt;
    logic [TMR_W-1:0] tmr;
    logic ahb_wr;
    logic [7:0] ahb_addr;
    logic [31:0] hrdata;
  } fmi_state_t;

  fmi_state_t q;
  fmi_state_t next_q;

  logic scl_s;
  logic scl_d;
  logic sda_s;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic cmd_end;
  logic has_arg;
  logic arg_ok;
  logic [7:0] new_byte;
  logic [15:0] tx_word;
  logic [7:0] tx_byte;
  logic [7:0] tx_crc;
  logic [7:0] arg_crc_calc;
  logic [15:0] status_word;
  logic smooth;
  logic [2:0] resp_code;
  logic [31:0] rd_data;

  // ==========================================================
  // Pin conditioning and bus events
  // Stage 0 feeds only stage 1; edges compare stages 1 and 2
  assign scl_s = q.scl_sy[1];
  assign scl_d = q.scl_sy[2];
  assign sda_s = q.sda_sy[1];
  assign sda_d = q.sda_sy[2];
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;
  assign new_byte = {q.sh[6:0], sda_s};
  assign cmd_end = (start_cond | stop_cond) & q.sel & ~q.rw;
  assign has_arg = (q.rx_cnt == RX_WITH_ARG);
  assign arg_ok = (q.rx_cnt == RX_CMD_ONLY) | (has_arg & (arg_crc_calc == q.arg_crc));

  // ==========================================================
  // Result words
  assign smooth = (q.avg == 9'h000) & (q.smooth_cnt == AUR_MAX_SAMPLES);
  always_comb
  begin
    status_word = 16'h0000;
    status_word[ST_ID_LSB +: 4] = MEAS_ID_AIR;
    status_word[ST_SMOOTH_BIT] = smooth;
    status_word[ST_FIXED_BIT] = (q.avg != 9'h000);
    status_word[ST_ARG_BIT] = q.arg_rcv;
    status_word[8:0] = q.avg;
  end

  always_comb
  begin
    unique case (q.filt)
      FILT_1MS: resp_code = RESP_1MS;
      FILT_3MS: resp_code = RESP_3MS;
      FILT_5MS: resp_code = RESP_5MS;
      FILT_10MS: resp_code = RESP_10MS;
      default: resp_code = RESP_OTHER;
    endcase
  end

  // Word order flow, temperature, status; each hi, lo, checksum
  always_comb
  begin
    unique case (q.word_idx)
      2'd0: tx_word = q.tx_flow;
      2'd1: tx_word = q.tx_temp;
      2'd2: tx_word = q.tx_stat;
      default: tx_word = 16'hFFFF;
    endcase
    unique case (q.byte_pos)
      2'd0: tx_byte = tx_word[15:8];
      2'd1: tx_byte = tx_word[7:0];
      default: tx_byte = tx_crc;
    endcase
    if (q.word_idx == 2'd3)
    begin
      tx_byte = IDLE_BYTE;
    end
  end

  fmi_crc8 u_tx_crc (
    .word_in(tx_word),
    .crc_out(tx_crc)
  );

  fmi_crc8 u_arg_crc (
    .word_in(q.arg),
    .crc_out(arg_crc_calc)
  );

  // ==========================================================
  // Register read mux
  always_comb
  begin
    rd_data = 32'h0000_0000;
    unique case (HADDR_IN[7:0])
      REG_SAMPLE: rd_data = {q.temp, q.flow};
      REG_STATUS:
      begin
        rd_data[RS_MEAS] = q.meas;
        rd_data[RS_READY] = q.ready;
        rd_data[RS_STOPPING] = q.stopping;
        rd_data[RS_ARG] = q.arg_rcv;
        rd_data[RS_SMOOTH] = smooth;
        rd_data[RS_RESP_LSB +: 3] = resp_code;
        rd_data[RS_FILT_LSB +: 16] = q.filt;
      end
      REG_CONFIG: rd_data = {23'h00_0000, q.avg};
      default: rd_data = 32'h0000_0000;
    endcase
    if (HADDR_IN[31:8] != 24'h00_0000)
    begin
      rd_data = 32'h0000_0000;
    end
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    next_q = q;
    next_q.scl_sy = {q.scl_sy[1:0], SCL_IN};
    next_q.sda_sy = {q.sda_sy[1:0], SDA_IN};
    next_q.ahb_wr = 1'b0;

    // Warm-up and power-down timer
    if (q.tmr != '0)
    begin
      next_q.tmr = q.tmr - 1'b1;
      if (q.tmr == TMR_W'(1))
      begin
        if (q.meas)
        begin
          next_q.ready = 1'b1;
        end
        next_q.stopping = 1'b0;
      end
    end

    // Command execution at STOP or repeated START
    if (cmd_end && arg_ok)
    begin
      if (q.cmd == CMD_SOFT_RESET)
      begin
        next_q.meas = 1'b0;
        next_q.ready = 1'b0;
        next_q.stopping = 1'b0;
        next_q.arg_rcv = 1'b0;
        next_q.filt = FILT_3MS;
        next_q.avg = AVG_DEFAULT;
        next_q.smooth_cnt = 8'h00;
        next_q.tmr = '0;
      end
      else if (q.meas)
      begin
        if (q.cmd == CMD_STOP)
        begin
          next_q.meas = 1'b0;
          next_q.ready = 1'b0;
          next_q.stopping = 1'b1;
          next_q.tmr = TMR_W'(STOP_CYC);
        end
      end
      else if (q.cmd == CMD_START)
      begin
        next_q.meas = 1'b1;
        next_q.ready = 1'b0;
        next_q.stopping = 1'b0;
        next_q.arg_rcv = has_arg;
        next_q.filt = has_arg ? q.arg : FILT_3MS;
        next_q.smooth_cnt = 8'h00;
        next_q.tmr = TMR_W'(WARM_CYC);
      end
      else if (q.cmd == CMD_AVERAGE && has_arg)
      begin
        next_q.avg = (q.arg > {7'h00, AVG_MAX}) ? AVG_MAX : q.arg[8:0];
      end
    end

    // Serial target
    if (start_cond)
    begin
      next_q.st = ST_ADDR;
      next_q.bit_cnt = 4'h0;
      next_q.sda_oe = 1'b0;
      next_q.sel = 1'b0;
    end
    else if (stop_cond)
    begin
      next_q.st = ST_IDLE;
      next_q.sda_oe = 1'b0;
      next_q.sel = 1'b0;
    end
    else
    begin
      unique case (q.st)
        ST_IDLE:
        begin
          next_q.sda_oe = 1'b0;
        end
        ST_ADDR:
        begin
          if (scl_rise)
          begin
            next_q.sh = new_byte;
            next_q.bit_cnt = q.bit_cnt + 1'b1;
            if (q.bit_cnt == 4'd7)
            begin
              next_q.rw = new_byte[0];
              next_q.rx_cnt = 3'h0;
              next_q.word_idx = 2'd0;
              next_q.byte_pos = 2'd0;
              if (new_byte[7:1] != DEV_ADDR)
              begin
                next_q.st = ST_IDLE;
              end
              else if (new_byte[0] && !q.ready)
              begin
                next_q.st = ST_IDLE;
              end
              else if (!new_byte[0] && q.stopping)
              begin
                next_q.st = ST_IDLE;
              end
              else
              begin
                next_q.st = ST_ACKW;
                next_q.ack = 1'b1;
                next_q.sel = 1'b1;
                if (new_byte[0])
                begin
                  next_q.tx_flow = q.flow;
                  next_q.tx_temp = q.temp;
                  next_q.tx_stat = status_word;
                  next_q.ready = 1'b0;
                  next_q.smooth_cnt = 8'h00;
                end
              end
            end
          end
        end
        ST_RX:
        begin
          if (scl_rise)
          begin
            next_q.sh = new_byte;
            next_q.bit_cnt = q.bit_cnt + 1'b1;
            if (q.bit_cnt == 4'd7)
            begin
              next_q.st = ST_ACKW;
              next_q.ack = (q.rx_cnt < RX_WITH_ARG);
              unique case (q.rx_cnt)
                3'd0: next_q.cmd[15:8] = new_byte;
                3'd1: next_q.cmd[7:0] = new_byte;
                3'd2: next_q.arg[15:8] = new_byte;
                3'd3: next_q.arg[7:0] = new_byte;
                3'd4: next_q.arg_crc = new_byte;
                default: next_q.ack = 1'b0;
              endcase
              if (q.rx_cnt < RX_WITH_ARG)
              begin
                next_q.rx_cnt = q.rx_cnt + 1'b1;
              end
            end
          end
        end
        ST_ACKW:
        begin
          if (scl_fall)
          begin
            next_q.sda_oe = q.ack;
            next_q.st = q.ack ? ST_ACK : ST_IDLE;
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            next_q.bit_cnt = 4'h0;
            if (q.rw)
            begin
              next_q.st = ST_TX;
              next_q.sda_oe = ~tx_byte[7];
              next_q.sh = {tx_byte[6:0], 1'b0};
              next_q.bit_cnt = 4'h1;
            end
            else
            begin
              next_q.st = ST_RX;
              next_q.sda_oe = 1'b0;
            end
          end
        end
        ST_TX:
        begin
          if (scl_fall)
          begin
            if (q.bit_cnt == 4'd8)
            begin
              next_q.sda_oe = 1'b0;
              next_q.st = ST_MACK;
            end
            else if (q.bit_cnt == 4'd0)
            begin
              next_q.sda_oe = ~tx_byte[7];
              next_q.sh = {tx_byte[6:0], 1'b0};
              next_q.bit_cnt = 4'h1;
            end
            else
            begin
              next_q.sda_oe = ~q.sh[7];
              next_q.sh = {q.sh[6:0], 1'b0};
              next_q.bit_cnt = q.bit_cnt + 1'b1;
            end
          end
        end
        ST_MACK:
        begin
          if (scl_rise)
          begin
            if (sda_s)
            begin
              next_q.st = ST_IDLE;
            end
            else
            begin
              next_q.st = ST_TX;
              next_q.bit_cnt = 4'h0;
              if (q.byte_pos == 2'd2)
              begin
                next_q.byte_pos = 2'd0;
                if (q.word_idx != 2'd3)
                begin
                  next_q.word_idx = q.word_idx + 1'b1;
                end
              end
              else
              begin
                next_q.byte_pos = q.byte_pos + 1'b1;
              end
            end
          end
        end
        default:
        begin
          next_q.st = ST_IDLE;
          next_q.sda_oe = 1'b0;
        end
      endcase
    end

    // Sample write from software; placed after the serial target so a fresh sample
    // wins over the ready clear of a simultaneous readout
    if (q.ahb_wr && q.ahb_addr == REG_SAMPLE)
    begin
      next_q.flow = HWDATA_IN[15:0];
      next_q.temp = HWDATA_IN[31:16];
      if (next_q.meas && q.tmr == '0)
      begin
        next_q.ready = 1'b1;
        if (q.avg == 9'h000 && next_q.smooth_cnt != AUR_MAX_SAMPLES)
        begin
          next_q.smooth_cnt = next_q.smooth_cnt + 1'b1;
        end
      end
    end

    // Address phase; read data is captured here for the data phase
    if (HSEL_IN && HTRANS_IN[1] && HREADY_IN)
    begin
      next_q.ahb_wr = HWRITE_IN;
      next_q.ahb_addr = (HADDR_IN[31:8] == 24'h00_0000) ? HADDR_IN[7:0] : 8'hFF;
      if (!HWRITE_IN)
      begin
        next_q.hrdata = rd_data;
      end
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      q <= '0;
      q.scl_sy <= 3'b111;
      q.sda_sy <= 3'b111;
      q.filt <= FILT_3MS;
      q.avg <= AVG_DEFAULT;
    end
    else
    begin
      q <= next_q;
    end
  end

  // ==========================================================
  // Outputs
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT = 1'b0;
  assign HRDATA_OUT = q.hrdata;
  assign SDA_OUT = 1'b0;
  assign SDA_OE_OUT = q.sda_oe;
  assign HEATER_OUT = q.meas;

endmodule : fmi_top

// [fmi_top_properties.sv]
// Purpose: Port properties of the serial flow meter target.
// Assumes: Bound to fmi_top, one clock domain.
// Notes: Serial bit timing and byte contents are judged by the bench.
`timescale 1ns/1ps
module fmi_top_properties
  import fmi_pkg::*;
#(
  parameter int WARM_CYC = WARM_CYCLES,
  parameter int STOP_CYC = STOP_CYCLES
)
(
  input wire logic CLK_IN, // Clock
  input wire logic SYS_RST_IN, // Reset
  input wire logic HSEL_IN, // Select
  input wire logic [31:0] HADDR_IN, // Address
  input wire logic [1:0] HTRANS_IN, // Transfer
  input wire logic HWRITE_IN, // Write
  input wire logic [2:0] HSIZE_IN, // Size
  input wire logic [31:0] HWDATA_IN, // Write data
  input wire logic HREADY_IN, // Bus ready
  input wire logic HREADYOUT_OUT, // Slave ready
  input wire logic HRESP_OUT, // Response
  input wire logic [31:0] HRDATA_OUT, // Read data
  input wire logic SCL_IN, // Serial clock
  input wire logic SDA_IN, // Data line
  input wire logic SDA_OUT, // Drive value
  input wire logic SDA_OE_OUT, // Drive enable
  input wire logic HEATER_OUT // Heater
);
  // ==========
  // Helpers
  logic rd_take;
  assign rd_take = HSEL_IN && HTRANS_IN[1] && HREADY_IN && !HWRITE_IN;
  function automatic logic [2:0] code_of(input logic [15:0] f);
    case (f)
      FILT_1MS: return RESP_1MS;
      FILT_3MS: return RESP_3MS;
      FILT_5MS: return RESP_5MS;
      FILT_10MS: return RESP_10MS;
      default: return RESP_OTHER;
    endcase
  endfunction : code_of
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);
  // ==========
  // Properties
  sda_free_a: assert property (SCL_IN [*8] |-> !SDA_OE_OUT)
    else $error("Data line held on an idle bus");
  heater_idle_a: assert property ($changed(HEATER_OUT) |-> SCL_IN && SDA_IN)
    else $error("Heater changed inside a frame");
  sda_drive_a: assert property (SDA_OE_OUT |-> !SDA_OUT)
    else $error("Data line driven high");
  oe_change_a: assert property ($changed(SDA_OE_OUT) |-> !SCL_IN)
    else $error("Data drive changed while clock high");
  ahb_okay_a: assert property (HREADYOUT_OUT && !HRESP_OUT)
    else $error("Bus answer not ready or not okay");
  rdata_hold_a: assert property (!$past(rd_take) |-> $stable(HRDATA_OUT))
    else $error("Read data moved without a read");
  unmapped_zero_a: assert property (rd_take && HADDR_IN != 32'h0 && HADDR_IN != 32'h4
    && HADDR_IN != 32'h8 |=> HRDATA_OUT == 32'h0)
    else $error("Unmapped read not zero");
  config_range_a: assert property (rd_take && HADDR_IN == 32'h8 |=>
    HRDATA_OUT[31:9] == 23'h0 && HRDATA_OUT[8:0] <= AVG_MAX)
    else $error("Average count out of range");
  status_map_a: assert property (rd_take && HADDR_IN == 32'h4 |=>
    HRDATA_OUT[7:5] == code_of(HRDATA_OUT[31:16]) && HRDATA_OUT[15:8] == 8'h0)
    else $error("Response code does not match filter");
endmodule : fmi_top_properties

bind fmi_top fmi_top_properties #(.WARM_CYC(WARM_CYC), .STOP_CYC(STOP_CYC)) u_props (
  .CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .HSEL_IN(HSEL_IN), .HADDR_IN(HADDR_IN),
  .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN), .HSIZE_IN(HSIZE_IN),
  .HWDATA_IN(HWDATA_IN), .HREADY_IN(HREADY_IN), .HREADYOUT_OUT(HREADYOUT_OUT),
  .HRESP_OUT(HRESP_OUT), .HRDATA_OUT(HRDATA_OUT), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT), .HEATER_OUT(HEATER_OUT));

// [fmi_ctl_model.sv]
// Purpose: Behavioural serial bus controller facing the flow meter target.
// Assumes: Open-drain data line resolved by the bench with a pull-up.
// Notes: Eight system clocks per bit; serial clock idles high between frames.
`timescale 1ns/1ps
module fmi_ctl_model
(
  input wire logic clk_in, // System clock
  input wire logic sda_in, // Resolved line
  output logic scl_out, // Serial clock
  output logic sda_pull_out // Pulls line low
);
  initial
  begin
    scl_out = 1'h1;
    sda_pull_out = 1'h0;
  end
  // ==========
  // Bit and frame tasks
  // Data set one clock after the fall, so setup is four clocks
  task automatic bit_io(input logic b, output logic r);
    scl_out <= 1'h0;
    @(posedge clk_in);
    sda_pull_out <= !b;
    repeat (4) @(posedge clk_in);
    scl_out <= 1'h1;
    repeat (3) @(posedge clk_in);
    r = sda_in;
  endtask : bit_io
  task automatic start_cond();
    sda_pull_out <= 1'h1;
    repeat (4) @(posedge clk_in);
  endtask : start_cond
  task automatic stop_cond();
    scl_out <= 1'h0;
    @(posedge clk_in);
    sda_pull_out <= 1'h1;
    repeat (4) @(posedge clk_in);
    scl_out <= 1'h1;
    repeat (4) @(posedge clk_in);
    sda_pull_out <= 1'h0;
    repeat (8) @(posedge clk_in);
  endtask : stop_cond
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'h1, r);
    ack = !r;
  endtask : wr_byte
  task automatic rd_byte(input logic more, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'h1, r);
      b[i] = r;
    end
    bit_io(!more, r);
  endtask : rd_byte
endmodule : fmi_ctl_model

// [fmi_top_tb.sv]
// Purpose: Self-checking bench of the flow meter serial target.
// Assumes: Software feeds samples over the register bus.
// Notes: Warm-up and power-down counts shortened to keep the run brief.
`timescale 1ns/1ps
module fmi_top_tb
  import fmi_pkg::*;
;
  localparam int WARM_C = 200;
  localparam int STOP_C = 200;
  localparam logic [7:0] WR_HDR = {DEV_ADDR, 1'h0};
  logic clk, rst, hsel, hwrite, scl, pull, ok, hrdy, sda, sda_o, sda_oe, heater;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, smp, r;
  logic [7:0] rb [9];
  int num_errors, n_checks;
  assign sda = !((sda_oe && !sda_o) || pull);
  fmi_top #(.WARM_CYC(WARM_C), .STOP_CYC(STOP_C)) uut (
    .CLK_IN(clk), .SYS_RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
    .HREADY_IN(hrdy), .HREADYOUT_OUT(hrdy), .HRESP_OUT(), .HRDATA_OUT(hrdata),
    .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe), .HEATER_OUT(heater));
  fmi_ctl_model ctl (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_pull_out(pull));
  initial
  begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  // ==========
  // Checking and bus tasks
  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_bit(input logic got, input logic exp);
    chk_reg({31'h0, got}, {31'h0, exp});
  endtask : chk_bit
  task automatic wait_ready();
    int k;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (hrdy !== 1'h1 && k < 16);
    if (hrdy !== 1'h1)
    begin
      num_errors++;
      report_and_stop();
    end
  endtask : wait_ready
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    wait_ready();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    r = hrdata;
  endtask : ahb
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'h0, a, 32'h0);
    chk_reg(r, exp);
  endtask : rd_chk
  // Checksum worked out bit by bit, high byte first
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 15; i >= 0; i--)
      c = (c[7] ^ w[i]) ? {c[6:0], 1'h0} ^ 8'h31 : {c[6:0], 1'h0};
    return c;
  endfunction : crc8
  task automatic send(input logic [7:0] hdr, input logic [15:0] cmd, input int nb,
                      input logic [15:0] arg, input logic [7:0] sum);
    logic [7:0] b [6];
    logic a;
    b = '{hdr, cmd[15:8], cmd[7:0], arg[15:8], arg[7:0], sum};
    ok = 1'h1;
    ctl.start_cond();
    for (int k = 0; k <= nb && ok; k++)
    begin
      ctl.wr_byte(b[k], a);
      ok = ok & a;
    end
    ctl.stop_cond();
  endtask : send
  task automatic read_res(input int n);
    ctl.start_cond();
    ctl.wr_byte({DEV_ADDR, 1'h1}, ok);
    for (int k = 0; k < n && ok; k++)
      ctl.rd_byte(k < n - 1, rb[k]);
    ctl.stop_cond();
  endtask : read_res
  // ==========
  // Main sequence
  initial
  begin
    logic [15:0] fl [5];
    logic [2:0] cd [5];
    logic [15:0] n;
    logic [15:0] w [3];
    logic [7:0] eb;
    logic [8:0] nv;
    fl = '{FILT_3MS, FILT_1MS, FILT_3MS, FILT_5MS, FILT_10MS};
    cd = '{RESP_3MS, RESP_1MS, RESP_3MS, RESP_5MS, RESP_10MS};
    num_errors = 0;
    n_checks = 0;
    rst = 1'h1;
    hsel = 1'h0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'h0;
    hwdata = 32'h0;
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    repeat (4) @(posedge clk);
    void'($urandom(32'h8309_17a3));
    rd_chk(REG_STATUS, {FILT_3MS, 8'h00, RESP_3MS, 5'h00});
    rd_chk(REG_CONFIG, {23'h0, AVG_DEFAULT});
    rd_chk(8'h0C, 32'h0);
    send({DEV_ADDR ^ 7'h01, 1'h0}, CMD_START, 2, 16'h0, 8'h0);
    chk_bit(ok, 1'h0);
    chk_bit(heater, 1'h0);
    read_res(1);
    chk_bit(ok, 1'h0);
    n = 16'(129 + $urandom % 65407);
    send(WR_HDR, CMD_AVERAGE, 5, n, crc8(n));
    chk_bit(ok, 1'h1);
    ahb(1'h1, REG_CONFIG, 32'hFFFF_FFFF);
    rd_chk(REG_CONFIG, {23'h0, AVG_MAX});
    send(WR_HDR, CMD_AVERAGE, 5, 16'h0005, ~crc8(16'h0005));
    rd_chk(REG_CONFIG, {23'h0, AVG_MAX});
    for (int i = 0; i < 5; i++)
    begin
      // Last run uses accumulate mode so status bit 10 is seen low
      nv = (i == 4) ? 9'h000 : AVG_MAX;
      if (i == 4)
        send(WR_HDR, CMD_AVERAGE, 5, 16'h0000, crc8(16'h0000));
      send(WR_HDR, CMD_START, i ? 5 : 2, fl[i], crc8(fl[i]));
      chk_bit(ok, 1'h1);
      chk_bit(heater, 1'h1);
      rd_chk(REG_STATUS, {fl[i], 8'h00, cd[i], 1'h0, i != 0, 3'h1});
      read_res(1);
      chk_bit(ok, 1'h0);
      smp = $urandom;
      ahb(1'h1, REG_SAMPLE, smp);
      repeat (WARM_C) @(posedge clk);
      w = '{smp[15:0], smp[31:16], {MEAS_ID_AIR, 1'h0, i != 4, i != 0, nv}};
      read_res(i == 2 ? 3 : 9);
      chk_bit(ok, 1'h1);
      for (int k = 0; k < (i == 2 ? 3 : 9); k++)
      begin
        eb = k % 3 == 2 ? crc8(w[k / 3]) : k % 3 == 0 ? w[k / 3][15:8] : w[k / 3][7:0];
        chk_reg({24'h00_0000, rb[k]}, {24'h00_0000, eb});
      end
      read_res(1);
      chk_bit(ok, 1'h0);
      send(WR_HDR, CMD_AVERAGE, 5, 16'h0001, crc8(16'h0001));
      rd_chk(REG_CONFIG, {23'h0, nv});
      send(WR_HDR, CMD_STOP, 2, 16'h0, 8'h0);
      chk_bit(heater, 1'h0);
      send(WR_HDR, CMD_STOP, 0, 16'h0, 8'h0);
      chk_bit(ok, 1'h0);
      repeat (STOP_C) @(posedge clk);
    end
    send(WR_HDR, CMD_START, 2, 16'h0, 8'h0);
    chk_bit(heater, 1'h1);
    send(WR_HDR, CMD_SOFT_RESET, 2, 16'h0, 8'h0);
    chk_bit(ok, 1'h1);
    chk_bit(heater, 1'h0);
    rd_chk(REG_CONFIG, {23'h0, AVG_DEFAULT});
    report_and_stop();
  end
endmodule : fmi_top_tb
